// *** design/eeprom_link.sv ***
// Functional notes
// - data changes only while clock low
// - falling data, clock high is start
// - rising data, clock high is stop
// - stop after read returns to standby
// - all items move as eight-bit words
// - slave acknowledges low in ninth clock
// - standby at power-up and after stop; after a write stop, busy first
// - data line only pulled low, never high
// - sample on rising, change after falling
// - busy write cycle ignores inputs, no acknowledge
// - eighth selection bit: one read, zero write
`timescale 1ns/1ps
`include "eeprom_link_regs.svh"
module eeprom_link
    import eeprom_link_pkg::*;
#(
    parameter int WRITE_CYCLES = `WRITE_CYCLE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output rx_word_t rx_word,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output logic standby,
    output logic busy
);
    // ------------------------------------------------------------
    // pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    // first stage only feeds second stage, avoids metastable fan-out
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg <= scl_sync_reg[1];
            sda_d_reg <= sda_sync_reg[1];
        end
    end
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    // data moving under a high clock is framing, not data
    assign start_ev = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_ev = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // ------------------------------------------------------------
    // framing state machine
    // ------------------------------------------------------------
    frame_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic first_reg;
    logic read_reg;
    logic wrote_reg;
    logic [31:0] wait_reg;
    logic drive_low_reg;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_STANDBY;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_reg <= 1'b0;
            read_reg <= 1'b0;
            wrote_reg <= 1'b0;
            wait_reg <= 32'h0;
        end else begin
            case (state_reg)
                ST_BUSY: begin
                    // bus is ignored until the write cycle ends
                    if (wait_reg == 32'h0) begin
                        state_reg <= ST_STANDBY;
                    end else begin
                        wait_reg <= wait_reg - 32'h1;
                    end
                end
                default: begin
                    if (start_ev) begin
                        state_reg <= ST_RECV;
                        bit_cnt_reg <= 4'h0;
                        first_reg <= 1'b1;
                        read_reg <= 1'b0;
                    end else if (stop_ev) begin
                        // a finished write sequence launches the timed cycle
                        if (wrote_reg && !read_reg) begin
                            state_reg <= ST_BUSY;
                            wait_reg <= 32'(WRITE_CYCLES - 1);
                        end else begin
                            state_reg <= ST_STANDBY;
                        end
                        wrote_reg <= 1'b0;
                    end else begin
                        case (state_reg)
                            ST_RECV: begin
                                if (scl_rise) begin
                                    shift_reg <= {shift_reg[6:0], sda_s};
                                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                end else if (scl_fall && bit_cnt_reg == `ACK_SLOT) begin
                                    state_reg <= ST_ACK;
                                end
                            end
                            ST_ACK: begin
                                if (scl_fall) begin
                                    bit_cnt_reg <= 4'h0;
                                    first_reg <= 1'b0;
                                    if (first_reg) begin
                                        read_reg <= shift_reg[`RW_BIT_POS];
                                    end else begin
                                        wrote_reg <= 1'b1;
                                    end
                                    if (first_reg && shift_reg[`RW_BIT_POS]) begin
                                        state_reg <= ST_SEND;
                                        shift_reg <= tx_data;
                                    end else begin
                                        state_reg <= ST_RECV;
                                    end
                                end
                            end
                            ST_SEND: begin
                                if (scl_fall) begin
                                    if (bit_cnt_reg == 4'h7) begin
                                        state_reg <= ST_MACK;
                                    end
                                    shift_reg <= {shift_reg[6:0], 1'b0};
                                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                                end
                            end
                            ST_MACK: begin
                                // controller low on ninth clock asks for more
                                if (scl_rise) begin
                                    first_reg <= sda_s;
                                end else if (scl_fall) begin
                                    bit_cnt_reg <= 4'h0;
                                    if (first_reg) begin
                                        state_reg <= ST_STANDBY;
                                    end else begin
                                        state_reg <= ST_SEND;
                                        shift_reg <= tx_data;
                                    end
                                    first_reg <= 1'b0;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // open-drain data pin and user outputs
    // ------------------------------------------------------------
    // low is the only level ever driven; high comes from the pull-up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_low_reg <= 1'b0;
        end else if (start_ev || stop_ev) begin
            drive_low_reg <= 1'b0;
        end else if (state_reg == ST_RECV && scl_fall && bit_cnt_reg == `ACK_SLOT) begin
            drive_low_reg <= 1'b1;
        end else if (state_reg == ST_ACK && scl_fall) begin
            drive_low_reg <= first_reg && shift_reg[`RW_BIT_POS] && !tx_data[7];
        end else if (state_reg == ST_SEND && scl_fall) begin
            drive_low_reg <= (bit_cnt_reg != 4'h7) && !shift_reg[6];
        end else if (state_reg == ST_MACK && scl_fall) begin
            drive_low_reg <= !first_reg && !tx_data[7];
        end else if (state_reg == ST_BUSY || state_reg == ST_STANDBY) begin
            drive_low_reg <= 1'b0;
        end
    end
    assign sda_out = 1'b0;
    assign sda_oe = drive_low_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_word <= '0;
            rx_valid <= 1'b0;
            tx_taken <= 1'b0;
        end else begin
            rx_valid <= state_reg == ST_RECV && scl_fall && bit_cnt_reg == `ACK_SLOT && !start_ev && !stop_ev;
            tx_taken <= (state_reg == ST_ACK && scl_fall && first_reg && shift_reg[`RW_BIT_POS])
                || (state_reg == ST_MACK && scl_fall && !first_reg);
            if (state_reg == ST_RECV && scl_fall && bit_cnt_reg == `ACK_SLOT) begin
                rx_word <= '{data: shift_reg, first: first_reg};
            end
        end
    end
    assign standby = state_reg == ST_STANDBY;
    assign busy = state_reg == ST_BUSY;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_never_high;
        @(posedge clk) disable iff (!rst_n) sda_oe |-> !sda_out;
    endproperty
    a_never_high: assert property (p_never_high) else $error("data pin driven high");
    property p_start_recv;
        @(posedge clk) disable iff (!rst_n) (start_ev && !busy) |=> state_reg == ST_RECV;
    endproperty
    a_start_recv: assert property (p_start_recv) else $error("start not taken");
    property p_stop_idle;
        @(posedge clk) disable iff (!rst_n) (stop_ev && !busy) |=> (standby || busy);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not obeyed");
    property p_read_stop;
        @(posedge clk) disable iff (!rst_n) (stop_ev && read_reg && !busy) |=> standby;
    endproperty
    a_read_stop: assert property (p_read_stop) else $error("no standby after read");
    property p_ack_low;
        @(posedge clk) disable iff (!rst_n)
            (state_reg == ST_RECV && scl_fall && bit_cnt_reg == 4'h8 && !stop_ev && !start_ev) |=> sda_oe;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("no acknowledge");
    property p_busy_quiet;
        @(posedge clk) disable iff (!rst_n) busy |=> !sda_oe;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive during write cycle");
    property p_busy_start;
        @(posedge clk) disable iff (!rst_n) (busy && wait_reg != 32'h0) |=> busy;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("left write cycle early");
    property p_pin_change;
        @(posedge clk) disable iff (!rst_n) $changed(sda_oe) |-> (!scl_s || start_ev || stop_ev || $past(stop_ev));
    endproperty
    a_pin_change: assert property (p_pin_change) else $error("data changed under high clock");
    property p_word_count;
        @(posedge clk) disable iff (!rst_n) rx_valid |-> $past(bit_cnt_reg) == 4'h8;
    endproperty
    a_word_count: assert property (p_word_count) else $error("word not eight bits");
    c_start: cover property (@(posedge clk) start_ev);
    c_ack: cover property (@(posedge clk) rx_valid);
    c_send: cover property (@(posedge clk) tx_taken);
    c_busy: cover property (@(posedge clk) busy);
endmodule

// *** design/eeprom_link_regs.svh ***
`ifndef EEPROM_LINK_REGS_SVH
`define EEPROM_LINK_REGS_SVH
// word framing
`define WORD_BITS 8
`define ACK_SLOT 4'h8
`define RW_BIT_POS 0
// internally timed write cycle, in nanoseconds, and clock period
`define WRITE_CYCLE_NS 5000000
`define CLK_PERIOD_NS 100
`define WRITE_CYCLE_CYCLES (`WRITE_CYCLE_NS / `CLK_PERIOD_NS)
`endif

// *** design/eeprom_link_pkg.sv ***
package eeprom_link_pkg;
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_RECV    = 3'b001,
        ST_ACK     = 3'b010,
        ST_SEND    = 3'b011,
        ST_MACK    = 3'b100,
        ST_BUSY    = 3'b101
    } frame_state_t;
    // one received word with its position in the frame
    typedef struct packed {
        logic [7:0] data;
        logic first;
    } rx_word_t;
endpackage

// *** dv/bus_ctrl_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// two-wire bus controller, open drain
// ----------------------------------------
module bus_ctrl_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // both lines released at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one 800 ns clock period; the long low phase covers the device's
    // four-cycle pin latency, so its data settles before the clock rises
    task automatic bit_io(input logic b, output logic r);
        tick(2);
        sda_low <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(1);
        r = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    // gap first so data never moves in the same cycle as the clock
    task automatic start();
        tick(2);
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
    endtask
    // returns only once the device has had time to act on the stop
    task automatic stop();
        tick(2);
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(6);
    endtask
    // eight bits then the ninth slot; released bits read the device
    task automatic xfer(input logic [7:0] wr, input logic last, output logic [7:0] rd, output logic ninth);
        for (int i = 7; i >= 0; i--) begin
            bit_io(wr[i], rd[i]);
        end
        bit_io(last, ninth);
    endtask
    // clock until the device lets go of data, then a fresh start
    task automatic recover(output int n);
        logic r;
        n = 0;
        r = 1'b0;
        while (!r && n < 9) begin
            bit_io(1'b1, r);
            n++;
        end
        start();
    endtask
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bench for the link framing block
// ----------------------------------------
module tb;
    import eeprom_link_pkg::*;
    localparam int WCYC = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl_in = 1'b1;
    logic sda_in = 1'b1;
    logic scl_prev = 1'b1;
    logic oe_prev = 1'b0;
    logic sda_out, sda_oe, rx_valid, tx_taken, standby, busy, scl_m, low_m;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] tx_next = 8'h00;
    logic [7:0] tx_first = 8'h00;
    logic [31:0] rng = 32'h0000004E;
    rx_word_t rx_word, last_rx;
    int n_fail = 0;
    int checks = 0;
    int ntx = 0;
    // pull-up: the wire is high unless someone pulls it low
    wire sda_bus = ~(low_m | sda_oe);
    eeprom_link #(.WRITE_CYCLES(WCYC)) uut (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .rx_word(rx_word), .rx_valid(rx_valid), .tx_data(tx_data),
        .tx_taken(tx_taken), .standby(standby), .busy(busy));
    bus_ctrl_model m (.clk(clk), .sda(sda_bus), .scl(scl_m), .sda_low(low_m));
    always #50 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // pins reach the design at the rising edge; a word is captured as it completes
    always @(posedge clk) begin
        scl_in <= scl_m;
        sda_in <= sda_bus;
        scl_prev <= scl_m;
        oe_prev <= sda_oe;
        if (rx_valid === 1'b1) last_rx <= rx_word;
        // the first byte of a read is offered while idle, later ones after each load
        if (tx_taken === 1'b1) begin
            ntx <= ntx + 1;
            tx_data <= tx_next;
        end else if (standby === 1'b1) begin
            tx_data <= tx_first;
        end
        // judged against the wire clock, not the delayed pin copy
        if (rst_n && scl_m && scl_prev && sda_oe !== oe_prev) check("oe moved with clock high", 0, 1);
        if (sda_out !== 1'b0) check("sda_out", 0, sda_out);
    end
    // watchdog sized well above the roughly 1250 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("unexpected watchdog: expected done seen timeout");
        end_sim();
    end
    initial begin
        logic [7:0] sel, dat, rd;
        logic ack;
        int n;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check("standby at power-up", 1, standby);
        check("oe at power-up", 0, sda_oe);
        $display("test reset done");
        // writes, then polling while the write cycle runs
        for (int k = 0; k < 2; k++) begin
            rng = xs(rng);
            sel = {rng[7:1], 1'b0};
            dat = rng[15:8];
            m.start();
            m.xfer(sel, 1'b1, rd, ack);
            check("selection ack", 0, ack);
            check("selection word", {sel, 1'b1}, last_rx);
            check("standby in frame", 0, standby);
            m.xfer(dat, 1'b1, rd, ack);
            check("data ack", 0, ack);
            check("data word", {dat, 1'b0}, last_rx);
            m.stop();
            check("busy after write", 1, busy);
            m.start();
            m.xfer(sel ^ 8'h10, 1'b1, rd, ack);
            check("ack while busy", 1, ack);
            check("word while busy", {dat, 1'b0}, last_rx);
            m.stop();
            check("busy after polling", 1, busy);
            n = 0;
            while (busy === 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            check("standby after write", 1, standby);
            $display("test write %0d done", k);
        end
        // read two bytes, acknowledge the first only
        rng = xs(rng);
        tx_first = rng[7:0];
        tx_next = rng[15:8];
        n = ntx;
        m.start();
        m.xfer({rng[23:17], 1'b1}, 1'b1, rd, ack);
        check("read select ack", 0, ack);
        m.xfer(8'hFF, 1'b0, rd, ack);
        check("read byte 0", rng[7:0], rd);
        m.xfer(8'hFF, 1'b1, rd, ack);
        check("read byte 1", rng[15:8], rd);
        check("bytes loaded", n + 2, ntx);
        m.stop();
        check("standby after read", 1, standby);
        $display("test read done");
        // read broken off after two bits of a zero byte, then recovery
        tx_first = 8'h00;
        tx_next = 8'h00;
        m.start();
        m.xfer(8'hA1, 1'b1, rd, ack);
        m.bit_io(1'b1, ack);
        m.bit_io(1'b1, ack);
        m.recover(n);
        check("recovery clocks", 7, n);
        m.xfer(8'hA0, 1'b1, rd, ack);
        check("ack after recovery", 0, ack);
        check("word after recovery", {8'hA0, 1'b1}, last_rx);
        m.stop();
        check("no write cycle", 0, busy);
        check("standby after recovery", 1, standby);
        $display("test recovery done");
        end_sim();
    end
endmodule
